/* File: pkg/tttx_pkg.sv */
// tttx_pkg: constants and carrier types for the trail trace transmitter.
// assumes a single 125 MHz clock and a synchronous active-high reset.
// Contract
// - align bit replaces first sent bit by default
// - align disable sends stored bytes unchanged
// - idle control sends all-zero identifier bytes
// - invert enable inverts bits after everything else
// - default order sends bit 7 first
// - reorder enable sends bit 0 first
// - four-bit pointer selects byte, zero first
// - pointer advances per access, wraps after fifteen
// - data port read or write advances pointer
// - registers reset zero, reserved bits read zero
package tttx_pkg;

  localparam logic [7:0] ADDR_CONTROL = 8'hE8;
  localparam logic [7:0] ADDR_POINTER = 8'hEA;
  localparam logic [7:0] ADDR_DATA = 8'hEC;

  localparam int CTRL_LSB_FIRST = 0;
  localparam int CTRL_INVERT = 1;
  localparam int CTRL_IDLE = 2;
  localparam int CTRL_ALIGN_DIS = 3;

  localparam logic [3:0] CONTROL_RESET = 4'h0;
  localparam logic [3:0] POINTER_RESET = 4'h0;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] IDLE_BYTE = 8'h00;
  localparam logic [15:0] READ_ZERO = 16'h0000;

  localparam int BUF_DEPTH = 16;
  localparam logic [3:0] POINTER_STEP = 4'h1;
  localparam logic [3:0] SLOT_FIRST = 4'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_STEP = 3'h1;
  localparam logic [2:0] BIT_FIRST = 3'h0;

  // alignment bit: set on the first byte of the identifier, clear elsewhere
  localparam logic ALIGN_BIT_FIRST = 1'b1;
  localparam logic ALIGN_BIT_OTHER = 1'b0;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [15:0] wdata;
  } tttx_host_req_t;

  typedef struct packed {
    logic first_bit;
    logic [3:0] byte_index;
    logic trace_bit;
  } tttx_bit_t;

endpackage : tttx_pkg

/* File: rtl/tttx_buf2.sv */
// tttx_buf2: two-entry buffer for outgoing trace bits.
// assumes the drain side may stall at any time; nothing is lost.
`timescale 1ns/1ps
module tttx_buf2 (
  input wire logic clk, // core clock
  input wire logic reset, // sync reset
  input wire logic in_valid, // word offered
  output logic in_ready, // room for a word
  input wire tttx_pkg::tttx_bit_t in_data, // word in
  output logic out_valid, // word held
  input wire logic out_ready, // drain accepts
  output tttx_pkg::tttx_bit_t out_data // oldest word
);
  tttx_pkg::tttx_bit_t mem [2];
  tttx_pkg::tttx_bit_t next_mem [2];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic next_wr_ptr;
  logic next_rd_ptr;
  logic [1:0] next_count;
  logic push;
  logic pop;

  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    next_mem = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push)
    begin
      next_mem[wr_ptr] = in_data;
      next_wr_ptr = ~wr_ptr;
    end
    if (pop)
    begin
      next_rd_ptr = ~rd_ptr;
    end
    if (push && !pop)
    begin
      next_count = count + 2'h1;
    end
    else if (pop && !push)
    begin
      next_count = count - 2'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      mem[0] <= '0;
      mem[1] <= '0;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end
    else
    begin
      mem <= next_mem;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end
endmodule : tttx_buf2

/* File: rtl/tttx_ser.sv */
// tttx_ser: shifts one prepared byte out, first bit in word bit 7.
// assumes the word is already ordered, marked and inverted.
`timescale 1ns/1ps
module tttx_ser (
  input wire logic clk, // core clock
  input wire logic reset, // sync reset
  input wire logic load_valid, // byte offered
  output logic load_ready, // ready for a byte
  input wire logic [7:0] load_word, // byte in send order
  input wire logic [3:0] load_index, // buffer location of byte
  output logic out_valid, // bit offered
  input wire logic out_ready, // bit accepted
  output tttx_pkg::tttx_bit_t out_bit // bit with marks
);
  typedef enum logic [0:0] {
    TTTX_SER_IDLE = 1'b0,
    TTTX_SER_SHIFT = 1'b1
  } tttx_ser_state_t;

  tttx_ser_state_t state;
  tttx_ser_state_t next_state;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [2:0] bit_count;
  logic [2:0] next_bit_count;
  logic [3:0] index;
  logic [3:0] next_index;

  assign load_ready = (state == TTTX_SER_IDLE);
  assign out_valid = (state == TTTX_SER_SHIFT);
  assign out_bit.trace_bit = shreg[7];
  assign out_bit.first_bit = (bit_count == tttx_pkg::BIT_FIRST);
  assign out_bit.byte_index = index;

  always_comb
  begin
    next_state = state;
    next_shreg = shreg;
    next_bit_count = bit_count;
    next_index = index;
    unique case (state)
      TTTX_SER_IDLE:
      begin
        if (load_valid)
        begin
          next_shreg = load_word;
          next_index = load_index;
          next_bit_count = tttx_pkg::BIT_FIRST;
          next_state = TTTX_SER_SHIFT;
        end
      end
      TTTX_SER_SHIFT:
      begin
        if (out_ready)
        begin
          next_shreg = {shreg[6:0], 1'b0};
          next_bit_count = bit_count + tttx_pkg::BIT_STEP;
          if (bit_count == tttx_pkg::BIT_LAST)
          begin
            next_state = TTTX_SER_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state <= TTTX_SER_IDLE;
      shreg <= tttx_pkg::BYTE_RESET;
      bit_count <= tttx_pkg::BIT_FIRST;
      index <= tttx_pkg::SLOT_FIRST;
    end
    else
    begin
      state <= next_state;
      shreg <= next_shreg;
      bit_count <= next_bit_count;
      index <= next_index;
    end
  end
endmodule : tttx_ser

/* File: rtl/tttx_top.sv */
// tttx_top: transmit trail trace generator with its three host registers.
// assumes one host access per cycle on rd/wr pulses and a framer that
// pulls trace bits through valid/ready, one bit per overhead slot.
`timescale 1ns/1ps
module tttx_top (
  input wire logic clk, // 125 MHz core clock
  input wire logic reset, // sync reset, active high
  input wire tttx_pkg::tttx_host_req_t host_req, // host strobes, address, data
  output logic [15:0] host_rdata, // read data, held until next read
  output logic trace_valid, // trace bit available
  input wire logic trace_ready, // framer takes the bit
  output tttx_pkg::tttx_bit_t trace_out // trace bit with byte marks
);
  logic [3:0] control;
  logic [3:0] next_control;
  logic [3:0] buffer_pointer;
  logic [3:0] next_buffer_pointer;
  logic [7:0] identifier_byte [tttx_pkg::BUF_DEPTH];
  logic [7:0] next_identifier_byte [tttx_pkg::BUF_DEPTH];
  logic [15:0] next_host_rdata;
  logic [3:0] slot;
  logic [3:0] next_slot;

  logic align_insert_disable;
  logic idle_identifier_select;
  logic output_invert_enable;
  logic lsb_first_enable;
  logic data_access;

  logic ser_load_ready;
  logic [7:0] load_word;
  logic [7:0] raw_byte;
  logic [7:0] ordered_byte;
  logic multiframe_align_bit;
  logic ser_valid;
  logic ser_ready;
  tttx_pkg::tttx_bit_t ser_bit;

  assign align_insert_disable = control[tttx_pkg::CTRL_ALIGN_DIS];
  assign idle_identifier_select = control[tttx_pkg::CTRL_IDLE];
  assign output_invert_enable = control[tttx_pkg::CTRL_INVERT];
  assign lsb_first_enable = control[tttx_pkg::CTRL_LSB_FIRST];

  // any read or write of the data port counts as a buffer access
  assign data_access = (host_req.rd || host_req.wr)
    && (host_req.addr == tttx_pkg::ADDR_DATA);

  // host register file
  always_comb
  begin
    next_control = control;
    next_buffer_pointer = buffer_pointer;
    next_identifier_byte = identifier_byte;
    next_host_rdata = host_rdata;
    if (host_req.wr)
    begin
      unique case (host_req.addr)
        tttx_pkg::ADDR_CONTROL:
        begin
          next_control = host_req.wdata[3:0];
        end
        tttx_pkg::ADDR_POINTER:
        begin
          next_buffer_pointer = host_req.wdata[3:0];
        end
        tttx_pkg::ADDR_DATA:
        begin
          next_identifier_byte[buffer_pointer] = host_req.wdata[7:0];
        end
        default:
        begin
          next_control = control;
        end
      endcase
    end
    else if (host_req.rd)
    begin
      unique case (host_req.addr)
        tttx_pkg::ADDR_CONTROL:
        begin
          next_host_rdata = {12'h000, control};
        end
        tttx_pkg::ADDR_POINTER:
        begin
          next_host_rdata = {12'h000, buffer_pointer};
        end
        tttx_pkg::ADDR_DATA:
        begin
          next_host_rdata = {8'h00, identifier_byte[buffer_pointer]};
        end
        default:
        begin
          next_host_rdata = tttx_pkg::READ_ZERO;
        end
      endcase
    end
    if (data_access)
    begin
      // 4-bit add wraps fifteen back to zero
      next_buffer_pointer = buffer_pointer + tttx_pkg::POINTER_STEP;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      control <= tttx_pkg::CONTROL_RESET;
      buffer_pointer <= tttx_pkg::POINTER_RESET;
      host_rdata <= tttx_pkg::READ_ZERO;
      for (int i = 0; i < tttx_pkg::BUF_DEPTH; i++)
      begin
        identifier_byte[i] <= tttx_pkg::BYTE_RESET;
      end
    end
    else
    begin
      control <= next_control;
      buffer_pointer <= next_buffer_pointer;
      host_rdata <= next_host_rdata;
      identifier_byte <= next_identifier_byte;
    end
  end

  // byte preparation for the serialiser
  always_comb
  begin
    raw_byte = idle_identifier_select ? tttx_pkg::IDLE_BYTE
      : identifier_byte[slot];
    for (int b = 0; b < 8; b++)
    begin
      ordered_byte[b] = lsb_first_enable ? raw_byte[7 - b] : raw_byte[b];
    end
    multiframe_align_bit = (slot == tttx_pkg::SLOT_FIRST)
      ? tttx_pkg::ALIGN_BIT_FIRST : tttx_pkg::ALIGN_BIT_OTHER;
    if (!align_insert_disable)
    begin
      ordered_byte[7] = multiframe_align_bit;
    end
    // with insertion disabled the ordered byte passes untouched
    load_word = output_invert_enable ? ~ordered_byte : ordered_byte;
  end

  // slot sequencing: walk locations 0..15 and repeat
  always_comb
  begin
    next_slot = slot;
    if (ser_load_ready)
    begin
      next_slot = slot + tttx_pkg::POINTER_STEP;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      slot <= tttx_pkg::SLOT_FIRST;
    end
    else
    begin
      slot <= next_slot;
    end
  end

  tttx_ser u_ser (
    .clk(clk),
    .reset(reset),
    .load_valid(1'b1),
    .load_ready(ser_load_ready),
    .load_word(load_word),
    .load_index(slot),
    .out_valid(ser_valid),
    .out_ready(ser_ready),
    .out_bit(ser_bit)
  );

  tttx_buf2 u_buf (
    .clk(clk),
    .reset(reset),
    .in_valid(ser_valid),
    .in_ready(ser_ready),
    .in_data(ser_bit),
    .out_valid(trace_valid),
    .out_ready(trace_ready),
    .out_data(trace_out)
  );
endmodule : tttx_top

/* File: test/tttx_top_chk.sv */
// tttx_top_chk: port-level assertions for the trace transmitter.
// assumes the ports of tttx_top; bound at the foot of this file.
`timescale 1ns/1ps
module tttx_top_chk (
  input wire logic clk, // core clock
  input wire logic reset, // sync reset
  input wire tttx_pkg::tttx_host_req_t host_req, // host access
  input wire logic [15:0] host_rdata, // read data
  input wire logic trace_valid, // bit offered
  input wire logic trace_ready, // bit taken
  input wire tttx_pkg::tttx_bit_t trace_out // bit with marks
);
  logic seen;
  logic [2:0] cnt;
  logic [3:0] idx;
  wire take = trace_valid && trace_ready;
  // bits taken within the current byte and the index of the last taken bit
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      seen <= 1'h0;
      cnt <= 3'h0;
      idx <= 4'h0;
    end
    else if (take)
    begin
      seen <= 1'h1;
      cnt <= cnt + 3'h1;
      idx <= trace_out.byte_index;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence rd_of(logic [7:0] a);
    host_req.rd && !host_req.wr && host_req.addr == a;
  endsequence
  sequence stall_s;
    trace_valid && !trace_ready;
  endsequence
  stall_hold_a: assert property (stall_s |=> trace_valid && $stable(trace_out))
    else $error("trace bit changed while stalled");
  rdata_keep_a: assert property (!host_req.rd |=> $stable(host_rdata))
    else $error("read data moved without a read");
  ctrl_rsvd_a: assert property (rd_of(8'hE8) |=> host_rdata[15:4] == 12'h000)
    else $error("control reserved bits not zero");
  ptr_rsvd_a: assert property (rd_of(8'hEA) |=> host_rdata[15:4] == 12'h000)
    else $error("pointer reserved bits not zero");
  data_rsvd_a: assert property (rd_of(8'hEC) |=> host_rdata[15:8] == 8'h00)
    else $error("data upper byte not zero");
  unmapped_zero_a: assert property (host_req.rd && !host_req.wr &&
    !(host_req.addr inside {8'hE8, 8'hEA, 8'hEC}) |=> host_rdata == 16'h0000)
    else $error("unmapped read not zero");
  bit_frame_a: assert property (trace_valid |-> trace_out.first_bit == (cnt == 3'h0))
    else $error("byte not eight bits long");
  byte_next_a: assert property (trace_valid && trace_out.first_bit && seen
    |-> trace_out.byte_index == idx + 4'h1)
    else $error("byte index not ascending");
  byte_same_a: assert property (trace_valid && !trace_out.first_bit |->
    trace_out.byte_index == idx)
    else $error("byte index changed within a byte");
  start_zero_a: assert property ($fell(reset) |-> ##[0:3]
    trace_valid && trace_out.first_bit && trace_out.byte_index == 4'h0)
    else $error("stream did not start at byte zero");
endmodule : tttx_top_chk

bind tttx_top tttx_top_chk i_tttx_top_chk (.clk(clk), .reset(reset), .host_req(host_req),
  .host_rdata(host_rdata), .trace_valid(trace_valid), .trace_ready(trace_ready),
  .trace_out(trace_out));

/* File: test/tttx_sink.sv */
// tttx_sink: framer side pulling trace bits, at full pace or with random stalls.
// assumes the bench picks the pace through slow.
`timescale 1ns/1ps
module tttx_sink (
  input wire logic clk, // core clock
  input wire logic reset, // sync reset
  input wire logic slow, // random stalls when high
  output logic trace_ready // bit taken
);
  int seed = 32'h3107;
  // held low by reset from the first edge on; one process drives it
  always @(posedge clk)
    trace_ready <= !reset && (!slow || $random(seed) % 2 == 0);
endmodule : tttx_sink

/* File: test/tttx_top_bench.sv */
// tttx_top_bench: self-checking bench for the trace transmitter.
// assumes tttx_top, tttx_sink and the bound checker.
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((e) !== (s)) begin errors++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
module tttx_top_bench;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic slow = 1'h0;
  logic armed = 1'h0;
  logic run = 1'h0;
  logic rd_seen = 1'h0;
  int errors = 0;
  int checked = 0;
  int seed = 32'h3107;
  tttx_pkg::tttx_host_req_t host_req = '0;
  logic [15:0] host_rdata;
  logic trace_valid;
  logic trace_ready;
  tttx_pkg::tttx_bit_t trace_out;
  tttx_pkg::tttx_bit_t et;
  logic [15:0] ev;
  logic [7:0] mem [16];
  logic [15:0] rq[$];
  tttx_pkg::tttx_bit_t tq[$];
  always #4 clk = ~clk;
  tttx_top i_tttx_top (.clk(clk), .reset(reset), .host_req(host_req), .host_rdata(host_rdata),
    .trace_valid(trace_valid), .trace_ready(trace_ready), .trace_out(trace_out));
  tttx_sink i_tttx_sink (.clk(clk), .reset(reset), .slow(slow), .trace_ready(trace_ready));

  task automatic wrap_up();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up

  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d, e);
    @(posedge clk);
    host_req <= '{rd: !w, wr: w, addr: a, wdata: d};
    if (!w)
      rq.push_back(e);
    @(posedge clk);
    host_req.rd <= 1'h0;
    host_req.wr <= 1'h0;
  endtask : acc

  function automatic tttx_pkg::tttx_bit_t exp_bit(logic [3:0] c, logic [3:0] k, int j);
    logic [7:0] v;
    logic b;
    v = c[tttx_pkg::CTRL_IDLE] ? 8'h00 : mem[k];
    b = c[tttx_pkg::CTRL_LSB_FIRST] ? v[j] : v[7 - j];
    if (j == 0 && !c[tttx_pkg::CTRL_ALIGN_DIS])
      b = (k == 4'h0);
    return '{first_bit: j == 0, byte_index: k, trace_bit: b ^ c[tttx_pkg::CTRL_INVERT]};
  endfunction : exp_bit

  // result watcher: read data the cycle after the read, trace bits once armed
  always @(posedge clk)
  begin
    if (rd_seen && rq.size() > 0)
    begin
      ev = rq.pop_front();
      `CHK("host_rdata", ev, host_rdata)
    end
    if (armed && trace_valid && trace_ready &&
        (run || (trace_out.first_bit && trace_out.byte_index == 4'h0)))
    begin
      run = 1'h1;
      et = tq.pop_front();
      `CHK("trace_out", et, trace_out)
      if (tq.size() == 0)
      begin
        armed = 1'h0;
        run = 1'h0;
      end
    end
    rd_seen <= host_req.rd;
  end

  initial
  begin
    logic [3:0] p;
    repeat (16) @(posedge clk);
    reset <= 1'h0;
    acc(0, 8'hE8, 0, 16'h0000);
    acc(0, 8'hEC, 0, 16'h0000);
    acc(0, 8'hEA, 0, 16'h0001);
    acc(1, 8'hE8, 16'hFFFF, 0);
    acc(0, 8'hE8, 0, 16'h000F);
    acc(1, 8'hEA, 16'hFFFF, 0);
    acc(0, 8'hEA, 0, 16'h000F);
    acc(1, 8'hEC, 16'h12AB, 0);
    acc(0, 8'hEA, 0, 16'h0000);
    acc(1, 8'hEA, 16'h000F, 0);
    acc(0, 8'hEC, 0, 16'h00AB);
    acc(0, 8'hEE, 0, 16'h0000);
    // a write to the unused address must leave control and pointer alone
    acc(1, 8'hEE, 16'h0000, 0);
    acc(0, 8'hE8, 0, 16'h000F);
    acc(0, 8'hEA, 0, 16'h0000);
    // every control setting, random bytes from a random start pointer
    for (int c = 0; c < 16; c++)
    begin
      p = 4'($random(seed));
      slow <= c[1];
      acc(1, 8'hEA, {12'h000, p}, 0);
      for (int i = 0; i < 16; i++)
      begin
        mem[p + 4'(i)] = 8'($random(seed));
        acc(1, 8'hEC, {8'h00, mem[p + 4'(i)]}, 0);
      end
      acc(1, 8'hE8, 16'(c), 0);
      repeat (300) @(posedge clk);
      for (int k = 0; k < 16; k++)
        for (int j = 0; j < 8; j++)
          tq.push_back(exp_bit(4'(c), 4'(k), j));
      armed = 1'h1;
      while (armed)
        @(posedge clk);
    end
    wrap_up();
  end

  initial
  begin
    repeat (30000) @(posedge clk);
    errors++;
    wrap_up();
  end
endmodule : tttx_top_bench
